/* hw/class_policy.sv */
// Class result policy: grade rules, power limit and standalone thresholds
`timescale 1ns/1ps
`include "poe_defs.svh"
module class_policy #(
    parameter logic [1:0] GRADE = `GRADE_A
) (
    input wire logic [3:0] cls_in,
    input wire logic classified,
    input wire logic high_power_en,
    input wire logic ext_power_en,
    input wire logic standalone,
    input wire logic [1:0] max_power,
    output logic [3:0] eff_cls,
    output logic allowed,
    output logic [9:0] icut,
    output logic [9:0] ilim
);
    // Effective class, admission and thresholds
    always_comb begin
        eff_cls = classified ? cls_in : `CLS_0;
        if (eff_cls[`CLS_EXT_BIT] && !(GRADE == `GRADE_A && high_power_en && ext_power_en)) begin
            eff_cls = `CLS_4;
        end
        if (GRADE == `GRADE_C && eff_cls == `CLS_4) begin
            eff_cls = `CLS_0;
        end
        allowed = !(standalone && eff_cls[`CLS_EXT_BIT] && (eff_cls[1:0] > max_power));
        ilim = `ILIM_LO;
        case (eff_cls)
            `CLS_1: icut = `ICUT_C1;
            `CLS_2: icut = `ICUT_C2;
            default: icut = `ICUT_C3;
        endcase
        if (eff_cls == `CLS_4 || eff_cls[`CLS_EXT_BIT]) begin
            icut = `ICUT_C4;
            ilim = `ILIM_HI;
        end
    end
endmodule : class_policy

/* hw/poe_port_mode_control.sv */
// Per-port operating-mode control for a multi-port power sourcing controller
//
// Summary of operation
// - Twelve ports, each in one of four modes
// - Mode field decode; 11b standalone needs select high
// - Manual: single detect or classify on command
// - Manual: power on or off on command anytime
// - Semi: repeat detect/classify, power only on command
// - Standalone: power automatically after good detection
// - Standalone only: thresholds set from class result
// - Shutdown: no detection, never power
// - Current limit fault removes power always
// - Enabled disconnect event removes power always
// - Host power-off command always honoured
// - Limit pins sampled at reset fix max power in standalone (90W otherwise)
// - Automatic power-up refuses extended classes above the selected power limit
// - Extended classes need high and extended enables
// - Lowest grade: no two-event, class 4 as 0
// - Unclassified device assumed to draw 13W
// - Reset pin or reset-all re-samples straps
// - Semi high power: power-on needs good detect
// - Detection off in shutdown, or with detect disabled outside manual
`timescale 1ns/1ps
`include "poe_defs.svh"
module poe_port_mode_control #(
    parameter int NPORTS = `NPORTS,
    parameter logic [1:0] GRADE = `GRADE_A,
    parameter int BACKOFF_CYC = `T_BACKOFF_MS * `MS_TO_US * `CLK_MHZ,
    parameter int MIDSPAN_CYC = `T_MIDSPAN_MS * `MS_TO_US * `CLK_MHZ
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reset_all,
    input wire logic standalone_sel,
    input wire logic midspan_sel,
    input wire logic power_limit_select_hi,
    input wire logic power_limit_select_lo,
    input wire logic high_power_en,
    input wire logic ext_power_en,
    input wire poe_pkg::port_cfg_t [NPORTS-1:0] cfg,
    input wire poe_pkg::port_cmd_t [NPORTS-1:0] cmd,
    input wire poe_pkg::fe_in_t [NPORTS-1:0] fe_in,
    output poe_pkg::fe_out_t [NPORTS-1:0] fe_out,
    output poe_pkg::port_reg_t [NPORTS-1:0] port_state,
    output poe_pkg::straps_t straps
);
    // ************************************************************
    // Types, constants and decoding
    // ************************************************************
    typedef struct packed {
        poe_pkg::port_reg_t [NPORTS-1:0] p;
    } state_t;

    localparam logic [`CNT_W-1:0] BACK_LD = `CNT_W'(BACKOFF_CYC - 1);
    localparam logic [`CNT_W-1:0] MID_LD = `CNT_W'(MIDSPAN_CYC - 1);

    // Mode field decode; standalone code without the standalone strap falls back to shutdown
    function automatic poe_pkg::op_mode_t decode_mode(input logic [1:0] field, input logic sa);
        case (field)
            `MODE_SA: decode_mode = sa ? poe_pkg::OP_SA : poe_pkg::OP_SHUT;
            `MODE_SEMI: decode_mode = poe_pkg::OP_SEMI;
            `MODE_MAN: decode_mode = poe_pkg::OP_MAN;
            default: decode_mode = poe_pkg::OP_SHUT;
        endcase
    endfunction : decode_mode

    state_t s_q, s_d;
    logic straps_pending;
    poe_pkg::straps_t straps_w;
    poe_pkg::op_mode_t md [NPORTS];
    logic kill [NPORTS];
    logic [3:0] pol_in [NPORTS];
    logic pol_valid [NPORTS];
    logic [3:0] eff_cls [NPORTS];
    logic allowed [NPORTS];
    logic [9:0] icut [NPORTS];
    logic [9:0] ilim [NPORTS];

    // ************************************************************
    // Strap capture
    // ************************************************************
    strap_sampler u_straps (
        .clk(clk),
        .reset_n(reset_n),
        .reset_all(reset_all),
        .standalone_sel(standalone_sel),
        .midspan_sel(midspan_sel),
        .power_limit_select_hi(power_limit_select_hi),
        .power_limit_select_lo(power_limit_select_lo),
        .pending(straps_pending),
        .straps(straps_w)
    );

    // ************************************************************
    // Per-port decode and class policy
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < NPORTS; g++) begin : g_port
            // Mode and power-removal conditions
            assign md[g] = decode_mode(cfg[g].port_mode_field, straps_w.standalone);
            assign kill[g] = fe_in[g].ilim_fault
                | (cfg[g].disc_en & fe_in[g].disconnect)
                | cmd[g].off
                | (md[g] == poe_pkg::OP_SHUT);
            // Policy sees the live result while classifying; a fresh detection counts as unclassified
            assign pol_in[g] = (s_q.p[g].st == poe_pkg::ST_CLASSIFY) ? fe_in[g].cls_res : s_q.p[g].cls;
            assign pol_valid[g] = (s_q.p[g].st == poe_pkg::ST_CLASSIFY)
                | ((s_q.p[g].st != poe_pkg::ST_DETECT) & s_q.p[g].classified);

            class_policy #(
                .GRADE(GRADE)
            ) u_policy (
                .cls_in(pol_in[g]),
                .classified(pol_valid[g]),
                .high_power_en(high_power_en),
                .ext_power_en(ext_power_en),
                .standalone(straps_w.standalone),
                .max_power(straps_w.max_power),
                .eff_cls(eff_cls[g]),
                .allowed(allowed[g]),
                .icut(icut[g]),
                .ilim(ilim[g])
            );

            // Outputs straight from the state flops
            assign fe_out[g].det_start = s_q.p[g].det_go;
            assign fe_out[g].cls_start = s_q.p[g].cls_go;
            assign fe_out[g].two_event = s_q.p[g].two_event;
            assign port_state[g] = s_q.p[g];
        end
    endgenerate

    assign straps = straps_w;

    // ************************************************************
    // Port sequencing
    // ************************************************************
    // Next state for every port: detection, classification, backoff, power
    always_comb begin
        poe_pkg::port_reg_t pr;
        logic try_power;
        logic end_cycle;
        pr = '0;
        try_power = 1'b0;
        end_cycle = 1'b0;
        s_d = s_q;
        for (int i = 0; i < NPORTS; i++) begin
            pr = s_q.p[i];
            try_power = 1'b0;
            end_cycle = 1'b0;
            pr.det_go = 1'b0;
            pr.cls_go = 1'b0;
            pr.fault = 1'b0;
            pr.two_event = (GRADE != `GRADE_C) & high_power_en;
            case (pr.st)
                poe_pkg::ST_IDLE: begin
                    if (md[i] == poe_pkg::OP_MAN) begin
                        if (cmd[i].detect) begin
                            pr.det_go = 1'b1;
                            pr.st = poe_pkg::ST_DETECT;
                        end else if (cmd[i].classify) begin
                            pr.cls_go = 1'b1;
                            pr.st = poe_pkg::ST_CLASSIFY;
                        end
                    end else if ((md[i] == poe_pkg::OP_SEMI || md[i] == poe_pkg::OP_SA) && cfg[i].det_en) begin
                        pr.det_go = 1'b1;
                        pr.st = poe_pkg::ST_DETECT;
                    end
                end
                poe_pkg::ST_DETECT: begin
                    if (fe_in[i].det_done) begin
                        pr.det = fe_in[i].det_res;
                        pr.cls = `CLS_0;
                        pr.classified = 1'b0;
                        if (md[i] == poe_pkg::OP_MAN) begin
                            pr.st = poe_pkg::ST_IDLE;
                        end else if (fe_in[i].det_res == `DET_GOOD && cfg[i].cls_en) begin
                            pr.cls_go = 1'b1;
                            pr.st = poe_pkg::ST_CLASSIFY;
                        end else if (fe_in[i].det_res == `DET_GOOD && md[i] == poe_pkg::OP_SA) begin
                            try_power = 1'b1;
                        end else begin
                            end_cycle = 1'b1;
                        end
                    end
                end
                poe_pkg::ST_CLASSIFY: begin
                    if (fe_in[i].cls_done) begin
                        pr.cls = eff_cls[i];
                        pr.classified = 1'b1;
                        if (md[i] == poe_pkg::OP_MAN) begin
                            pr.st = poe_pkg::ST_IDLE;
                        end else if (md[i] == poe_pkg::OP_SA && pr.det == `DET_GOOD) begin
                            try_power = 1'b1;
                        end else begin
                            end_cycle = 1'b1;
                        end
                    end
                end
                poe_pkg::ST_BACKOFF: begin
                    if (pr.cnt != '0) begin
                        pr.cnt = pr.cnt - `CNT_W'(1);
                    end else if (cfg[i].det_en && md[i] != poe_pkg::OP_MAN) begin
                        pr.det_go = 1'b1;
                        pr.st = poe_pkg::ST_DETECT;
                    end else begin
                        pr.st = poe_pkg::ST_IDLE;
                    end
                end
                poe_pkg::ST_POWERED: begin
                    pr.power = 1'b1;
                end
                default: begin
                    pr.st = poe_pkg::ST_IDLE;
                end
            endcase
            // Automatic power-up in standalone mode within the sampled limit
            if (try_power) begin
                if (allowed[i]) begin
                    pr.power = 1'b1;
                    pr.st = poe_pkg::ST_POWERED;
                    pr.auto_th = 1'b1;
                    pr.icut = icut[i];
                    pr.ilim = ilim[i];
                end else begin
                    end_cycle = 1'b1;
                end
            end
            // Wait before the next detection; longer for a midspan
            if (end_cycle) begin
                pr.st = poe_pkg::ST_BACKOFF;
                pr.cnt = straps_w.midspan ? MID_LD : BACK_LD;
            end
            // Host power-on command
            if (cmd[i].on && !pr.power && md[i] != poe_pkg::OP_SHUT) begin
                if (md[i] != poe_pkg::OP_MAN && high_power_en && s_q.p[i].det != `DET_GOOD) begin
                    pr.fault = 1'b1;
                end else begin
                    pr.power = 1'b1;
                    pr.st = poe_pkg::ST_POWERED;
                    pr.det_go = 1'b0;
                    pr.cls_go = 1'b0;
                end
            end
            // Power removal and shutdown override everything else
            if (kill[i]) begin
                pr.power = 1'b0;
                pr.auto_th = 1'b0;
                if (pr.st == poe_pkg::ST_POWERED || md[i] == poe_pkg::OP_SHUT) begin
                    pr.st = poe_pkg::ST_IDLE;
                end
                if (md[i] == poe_pkg::OP_SHUT) begin
                    pr.det_go = 1'b0;
                    pr.cls_go = 1'b0;
                end
            end
            // Thresholds are only automatic in standalone mode
            if (md[i] != poe_pkg::OP_SA) begin
                pr.auto_th = 1'b0;
            end
            s_d.p[i] = pr;
        end
        // Ports stay idle until the straps are captured
        if (straps_pending || reset_all) begin
            s_d = '0;
        end
    end

    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    generate
        for (g = 0; g < NPORTS; g++) begin : g_chk
            a_shutdown_no_power:
            assert property (@(posedge clk) disable iff (!reset_n)
                md[g] == poe_pkg::OP_SHUT |=> !port_state[g].power && !fe_out[g].det_start)
                else $error("shutdown port powered or detecting");
            a_fault_power_off:
            assert property (@(posedge clk) disable iff (!reset_n)
                fe_in[g].ilim_fault |=> !port_state[g].power)
                else $error("power kept after current limit fault");
            a_disconnect_off:
            assert property (@(posedge clk) disable iff (!reset_n)
                cfg[g].disc_en && fe_in[g].disconnect |=> !port_state[g].power)
                else $error("power kept after disconnect");
            a_host_off:
            assert property (@(posedge clk) disable iff (!reset_n)
                cmd[g].off |=> !port_state[g].power)
                else $error("power-off command ignored");
            a_manual_quiet:
            assert property (@(posedge clk) disable iff (!reset_n)
                md[g] == poe_pkg::OP_MAN && port_state[g].st == poe_pkg::ST_IDLE && !cmd[g].detect
                |=> !fe_out[g].det_start)
                else $error("manual port detected without command");
            a_manual_on:
            assert property (@(posedge clk) disable iff (!reset_n)
                md[g] == poe_pkg::OP_MAN && cmd[g].on && !kill[g] && !reset_all && !straps_pending
                |=> port_state[g].power)
                else $error("manual power-on ignored");
            a_semi_no_auto:
            assert property (@(posedge clk) disable iff (!reset_n)
                md[g] == poe_pkg::OP_SEMI && !cmd[g].on && !port_state[g].power |=> !port_state[g].power)
                else $error("semi port powered without command");
            a_semi_hp_fault:
            assert property (@(posedge clk) disable iff (!reset_n)
                md[g] == poe_pkg::OP_SEMI && high_power_en && cmd[g].on && !port_state[g].power
                && port_state[g].det != `DET_GOOD && !reset_all && !straps_pending
                |=> port_state[g].fault && !port_state[g].power)
                else $error("semi power-on without good detect");
            a_auto_thresh:
            assert property (@(posedge clk) disable iff (!reset_n)
                $rose(port_state[g].auto_th) |-> $past(md[g] == poe_pkg::OP_SA))
                else $error("thresholds set outside standalone mode");
            a_grade_c_class:
            assert property (@(posedge clk) disable iff (!reset_n)
                GRADE == `GRADE_C && port_state[g].classified |-> port_state[g].cls != `CLS_4
                && !fe_out[g].two_event)
                else $error("lowest grade kept class 4");
        end
    endgenerate
endmodule : poe_port_mode_control

/* hw/strap_sampler.sv */
// Strap capture of standalone, midspan and power-limit pins after reset
`timescale 1ns/1ps
`include "poe_defs.svh"
module strap_sampler (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reset_all,
    input wire logic standalone_sel,
    input wire logic midspan_sel,
    input wire logic power_limit_select_hi,
    input wire logic power_limit_select_lo,
    output logic pending,
    output poe_pkg::straps_t straps
);
    typedef struct packed {
        logic pending;
        poe_pkg::straps_t straps;
    } state_t;
    state_t s_q, s_d;

    // Capture once after reset release or a reset-all request
    always_comb begin
        s_d = s_q;
        if (reset_all) begin
            s_d.pending = 1'b1;
        end else if (s_q.pending) begin
            s_d.pending = 1'b0;
            s_d.straps.standalone = standalone_sel;
            s_d.straps.midspan = midspan_sel;
            s_d.straps.max_power = standalone_sel ? {power_limit_select_hi, power_limit_select_lo} : `PL_90W;
        end
    end

    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{pending: 1'b1, straps: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign pending = s_q.pending;
    assign straps = s_q.straps;

    a_strap_hold:
    assert property (@(posedge clk) disable iff (!reset_n) (!pending && !reset_all) |=> $stable(straps))
        else $error("straps changed without a reset");
endmodule : strap_sampler

/* inc/poe_defs.svh */
// Constants for the per-port operating-mode controller
`ifndef POE_DEFS_SVH
`define POE_DEFS_SVH
`define NPORTS 12
`define MODE_SHUT 2'h0
`define MODE_MAN 2'h1
`define MODE_SEMI 2'h2
`define MODE_SA 2'h3
`define DET_UNKNOWN 3'h0
`define DET_GOOD 3'h4
`define CLS_0 4'h0
`define CLS_1 4'h1
`define CLS_2 4'h2
`define CLS_4 4'h4
`define CLS_EXT_BIT 3
`define GRADE_A 2'h0
`define GRADE_B 2'h1
`define GRADE_C 2'h2
`define PL_90W 2'h3
`define ICUT_C1 10'h070
`define ICUT_C2 10'h0CE
`define ICUT_C3 10'h177
`define ICUT_C4 10'h27E
`define ILIM_LO 10'h1A9
`define ILIM_HI 10'h352
`define CNT_W 28
`define CLK_MHZ 125
`define MS_TO_US 1000
`define T_BACKOFF_MS 100
`define T_MIDSPAN_MS 2000
`endif

/* inc/poe_pkg.sv */
// Types shared by the port mode controller and its helpers
`include "poe_defs.svh"
package poe_pkg;
    typedef enum logic [1:0] {
        OP_SHUT = 2'b00, OP_MAN = 2'b01, OP_SEMI = 2'b10, OP_SA = 2'b11
    } op_mode_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_DETECT = 3'b001, ST_CLASSIFY = 3'b010, ST_BACKOFF = 3'b011, ST_POWERED = 3'b100
    } port_state_t;
    typedef struct packed {
        logic [1:0] port_mode_field;
        logic det_en;
        logic cls_en;
        logic disc_en;
    } port_cfg_t;
    typedef struct packed {
        logic detect;
        logic classify;
        logic on;
        logic off;
    } port_cmd_t;
    typedef struct packed {
        logic det_done;
        logic [2:0] det_res;
        logic cls_done;
        logic [3:0] cls_res;
        logic ilim_fault;
        logic disconnect;
    } fe_in_t;
    typedef struct packed {
        logic det_start;
        logic cls_start;
        logic two_event;
    } fe_out_t;
    typedef struct packed {
        logic standalone;
        logic midspan;
        logic [1:0] max_power;
    } straps_t;
    typedef struct packed {
        port_state_t st;
        logic power;
        logic det_go;
        logic cls_go;
        logic fault;
        logic two_event;
        logic [2:0] det;
        logic [3:0] cls;
        logic classified;
        logic auto_th;
        logic [9:0] icut;
        logic [9:0] ilim;
        logic [`CNT_W-1:0] cnt;
    } port_reg_t;
endpackage : poe_pkg

/* testbench/pd_front_model.sv */
// Powered-device front end answering detection and classification starts
`timescale 1ns/1ps
`include "poe_defs.svh"
module pd_front_model #(
    parameter int NPORTS = 12
) (
    input wire logic clk,
    input wire poe_pkg::fe_out_t [NPORTS-1:0] fe_out,
    input wire logic [2:0] det_val,
    input wire logic [3:0] cls_val,
    input wire logic [NPORTS-1:0] ilim,
    input wire logic [NPORTS-1:0] disc,
    output poe_pkg::fe_in_t [NPORTS-1:0] fe_in
);
    int dly_det [NPORTS];
    int dly_cls [NPORTS];
    initial fe_in = '0;
    // *****************************************
    // Answer two cycles after a start
    // *****************************************
    // Result lines carry the inverse value outside the done pulse
    always @(negedge clk) begin
        for (int i = 0; i < NPORTS; i++) begin
            if (fe_out[i].det_start === 1'b1) begin
                dly_det[i] = 3;
            end else if (dly_det[i] > 0) begin
                dly_det[i] = dly_det[i] - 1;
            end
            if (fe_out[i].cls_start === 1'b1) begin
                dly_cls[i] = 3;
            end else if (dly_cls[i] > 0) begin
                dly_cls[i] = dly_cls[i] - 1;
            end
            fe_in[i].det_done <= (dly_det[i] == 1);
            fe_in[i].det_res <= (dly_det[i] == 1) ? det_val : ~det_val;
            fe_in[i].cls_done <= (dly_cls[i] == 1);
            fe_in[i].cls_res <= (dly_cls[i] == 1) ? cls_val : ~cls_val;
            fe_in[i].ilim_fault <= ilim[i];
            fe_in[i].disconnect <= disc[i];
        end
    end
endmodule : pd_front_model

/* testbench/testbench.sv */
// Self-checking bench for the port mode controller
`timescale 1ns/1ps
`include "poe_defs.svh"
module testbench;
    localparam int NP = 12;
    logic clk, reset_n, reset_all, standalone_sel, midspan_sel, lim_hi, lim_lo, high_power_en, ext_power_en;
    poe_pkg::port_cfg_t [NP-1:0] cfg;
    poe_pkg::port_cmd_t [NP-1:0] cmd;
    poe_pkg::fe_in_t [NP-1:0] fe_in;
    poe_pkg::fe_out_t [NP-1:0] fe_out;
    poe_pkg::port_reg_t [NP-1:0] port_state;
    poe_pkg::port_reg_t [NP-1:0] port_state_c;
    poe_pkg::straps_t straps;
    logic [2:0] det_val;
    logic [3:0] cls_val;
    logic [NP-1:0] ilim, disc;
    int nstart [NP];
    int n_mismatch = 0;
    int n_compared = 0;
    int s0;
    always #4 clk = ~clk;
    poe_port_mode_control #(.NPORTS(NP), .GRADE(`GRADE_A), .BACKOFF_CYC(8), .MIDSPAN_CYC(16)) u_dut (
        .clk(clk), .reset_n(reset_n), .reset_all(reset_all), .standalone_sel(standalone_sel),
        .midspan_sel(midspan_sel), .power_limit_select_hi(lim_hi), .power_limit_select_lo(lim_lo),
        .high_power_en(high_power_en), .ext_power_en(ext_power_en), .cfg(cfg), .cmd(cmd),
        .fe_in(fe_in), .fe_out(fe_out), .port_state(port_state), .straps(straps));
    // Lowest grade copy sharing the stimulus and the front end
    poe_port_mode_control #(.NPORTS(NP), .GRADE(`GRADE_C), .BACKOFF_CYC(8), .MIDSPAN_CYC(16)) u_dut_c (
        .clk(clk), .reset_n(reset_n), .reset_all(reset_all), .standalone_sel(standalone_sel),
        .midspan_sel(midspan_sel), .power_limit_select_hi(lim_hi), .power_limit_select_lo(lim_lo),
        .high_power_en(high_power_en), .ext_power_en(ext_power_en), .cfg(cfg), .cmd(cmd),
        .fe_in(fe_in), .fe_out(), .port_state(port_state_c), .straps());
    pd_front_model #(.NPORTS(NP)) u_pd (.clk(clk), .fe_out(fe_out), .det_val(det_val), .cls_val(cls_val),
        .ilim(ilim), .disc(disc), .fe_in(fe_in));
    // Count detection starts per port
    always @(posedge clk) begin
        for (int i = 0; i < NP; i++) begin
            if (fe_out[i].det_start === 1'b1) nstart[i]++;
        end
    end
    // *****************************************
    // Shared tasks
    // *****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n
    // One-cycle command; returns where the registered answer is visible
    task automatic pulse(input int p, input logic [3:0] c);
        @(negedge clk);
        cmd[p] <= c;
        @(negedge clk);
        cmd[p] <= 4'h0;
    endtask : pulse
    task automatic strap_reset(input logic sa, input logic [1:0] lim);
        @(negedge clk);
        standalone_sel <= sa;
        {lim_hi, lim_lo} <= lim;
        reset_all <= 1'b1;
        @(negedge clk);
        reset_all <= 1'b0;
        wait_n(3);
    endtask : strap_reset
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        #(20000 * 8);
        n_mismatch++;
        give_verdict();
    end
    // *****************************************
    // Test sequence
    // *****************************************
    initial begin
        clk = 1'b0; reset_n = 1'b0; reset_all = 1'b0; standalone_sel = 1'b1; midspan_sel = 1'b0;
        lim_hi = 1'b1; lim_lo = 1'b1; high_power_en = 1'b1; ext_power_en = 1'b0;
        cmd = '0; det_val = `DET_GOOD; cls_val = `CLS_4; ilim = '0; disc = '0; cfg = '0;
        cfg[0] = 5'h04; // Shutdown with detect enabled
        cfg[1] = 5'h08; // Manual
        cfg[2] = 5'h16;
        cfg[3] = 5'h10; // Semi, detect disabled
        cfg[4] = 5'h1F; // Standalone, all enables
        cfg[5] = 5'h1C; // Standalone, detect only
        repeat (16) @(negedge clk);
        reset_n <= 1'b1;
        wait_n(4);
        check(straps, 4'hB);
        s0 = nstart[1];
        pulse(1, 4'h8);
        check(fe_out[1].det_start, 1);
        wait_n(40);
        check(nstart[1] - s0, 1);
        check(port_state[1].det, `DET_GOOD);
        pulse(1, 4'h2);
        check(port_state[1].power, 1);
        pulse(1, 4'h1);
        check(port_state[1].power, 0);
        check(nstart[0], 0);
        check(nstart[2] >= 2, 1);
        check(port_state[2].power, 0);
        check(port_state[2].auto_th, 0);
        check(nstart[3], 0);
        pulse(3, 4'h2);
        check({port_state[3].fault, port_state[3].power}, 2'h2);
        pulse(0, 4'h2);
        check(port_state[0].power, 0);
        pulse(2, 4'h2);
        check(port_state[2].power, 1);
        ilim[2] <= 1'b1;
        wait_n(3);
        check(port_state[2].power, 0);
        ilim[2] <= 1'b0;
        check(port_state[4].power, 1);
        check({port_state[4].auto_th, port_state[4].cls}, {1'b1, `CLS_4});
        check({port_state[4].icut, port_state[4].ilim}, {`ICUT_C4, `ILIM_HI});
        check({port_state[5].icut, port_state[5].ilim}, {`ICUT_C3, `ILIM_LO});
        check({port_state_c[4].power, port_state_c[4].cls, port_state_c[4].two_event}, {1'b1, `CLS_0, 1'b0});
        disc[4] <= 1'b1;
        wait_n(3);
        check(port_state[4].power, 0);
        disc[4] <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            strap_reset(1'b1, k[1:0]);
            check(straps.max_power, k[1:0]);
        end
        {lim_hi, lim_lo} <= 2'h0;
        wait_n(4);
        check(straps.max_power, 2'h3);
        // Extended class above the lowest limit, midspan backoff
        cls_val <= 4'h9;
        ext_power_en <= 1'b1;
        midspan_sel <= 1'b1;
        strap_reset(1'b1, 2'h0);
        check(straps, 4'hC);
        wait_n(40);
        check(port_state[4].power, 0);
        check(port_state[4].cls, 4'h9);
        ext_power_en <= 1'b0;
        wait_n(40);
        check({port_state[4].power, port_state[4].cls}, {1'b1, `CLS_4});
        strap_reset(1'b0, 2'h0);
        check(straps.standalone, 0);
        s0 = nstart[4];
        wait_n(40);
        check(nstart[4] - s0, 0);
        check(port_state[4].power, 0);
        give_verdict();
    end
endmodule : testbench
